// ==== design/cfg_consts.vh ====
// constants for the converter configuration register bank
// assumes a 32-bit ahb-lite slave decoding word addresses
`ifndef CFG_CONSTS_VH
`define CFG_CONSTS_VH
// ************
// register indices, byte address is four times the index
// ************
`define IDX_CHANNEL_SELECT 8'h12
`define IDX_LOOP_SETTLING 8'h14
`define IDX_UPDATE_MODE 8'h15
`define IDX_OUTPUT_SPAN 8'h16
// ************
// reset values
// ************
`define RST_CHANNEL_SELECT 16'h0000
`define RST_LOOP_SETTLING 16'h2222
`define RST_UPDATE_MODE 16'h0000
`define RST_OUTPUT_SPAN 16'h0000
// ************
// writable masks: reserved bits are kept
// ************
`define MASK_CHANNEL_SELECT 16'h7fff
`define MASK_LOOP_SETTLING 16'hffff
`define MASK_UPDATE_MODE 16'h00ff
`define MASK_OUTPUT_SPAN 16'h00ff
// ************
// field positions
// ************
`define POS_LOCAL_TEMP 14
`define POS_REMOTE_TEMP 12
`define POS_CURRENT_SENSE 8
`define POS_EXTERNAL_IN 4
`define POS_INTERNAL_IN 0
`define POS_AUX_FIELD 4
`define POS_PRIMARY_FIELD 0
`define POS_PAIR_B_SPAN 2
`define POS_PAIR_A_SPAN 0
// ************
// settle codes and bipolar span codes
// ************
`define SETTLE_MAX_CODE 4'ha
`define SPAN_NEG4_POS1 2'h0
`define SPAN_NEG5_ZERO_A 2'h1
`define SPAN_NEG5_ZERO_B 2'h2
`define SPAN_ZERO_POS5 2'h3
// settling time in units of 0.1 ms
`define SETTLE_TENTHS_MS_0 9'h008
`define SETTLE_TENTHS_MS_1 9'h010
`define SETTLE_TENTHS_MS_2 9'h018
`define SETTLE_TENTHS_MS_3 9'h020
`define SETTLE_TENTHS_MS_4 9'h030
`define SETTLE_TENTHS_MS_5 9'h040
`define SETTLE_TENTHS_MS_6 9'h060
`define SETTLE_TENTHS_MS_7 9'h080
`define SETTLE_TENTHS_MS_8 9'h0c0
`define SETTLE_TENTHS_MS_9 9'h100
`define SETTLE_TENTHS_MS_10 9'h120
`define CLK_HZ 20000000
`endif

// ==== design/cfg_word.v ====
// one 16-bit configuration word with per-bit write mask
// assumes write strobe and data come from the bus slave on hclk
`timescale 1ns/1ns
module cfg_word #(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter [15:0] WRITE_MASK = 16'hffff
) (
    input wire hclk, // clock
    input wire hresetn, // async reset, active low
    input wire write_en, // one-cycle write strobe
    input wire [15:0] write_data, // value to store
    output reg [15:0] value // stored value
);
    // reserved bits never change so they read back their zero reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value <= RESET_VALUE;
        end else if (write_en) begin
            value <= (write_data & WRITE_MASK) | (value & ~WRITE_MASK);
        end
    end
endmodule // cfg_word

// ==== design/settle_decode.v ====
// maps one 4-bit settle code to a settling time and a cycle count
// assumes the code comes from a register on the same clock
`timescale 1ns/1ns
`include "cfg_consts.vh"
module settle_decode (
    input wire [3:0] code, // settle code
    output reg [8:0] tenths_ms, // settling time, 0.1 ms units
    output wire valid, // code is in the legal range
    output wire [31:0] cycles // settling time in hclk cycles
);
    always @* begin
        case (code)
            4'h0: tenths_ms = `SETTLE_TENTHS_MS_0;
            4'h1: tenths_ms = `SETTLE_TENTHS_MS_1;
            4'h2: tenths_ms = `SETTLE_TENTHS_MS_2;
            4'h3: tenths_ms = `SETTLE_TENTHS_MS_3;
            4'h4: tenths_ms = `SETTLE_TENTHS_MS_4;
            4'h5: tenths_ms = `SETTLE_TENTHS_MS_5;
            4'h6: tenths_ms = `SETTLE_TENTHS_MS_6;
            4'h7: tenths_ms = `SETTLE_TENTHS_MS_7;
            4'h8: tenths_ms = `SETTLE_TENTHS_MS_8;
            4'h9: tenths_ms = `SETTLE_TENTHS_MS_9;
            4'ha: tenths_ms = `SETTLE_TENTHS_MS_10;
            default: tenths_ms = 9'h000;
        endcase
    end
    assign valid = (code <= `SETTLE_MAX_CODE);
    // 0.1 ms is clk/10000 cycles; invalid codes give zero
    assign cycles = tenths_ms * (`CLK_HZ / 10000);
endmodule // settle_decode

// ==== design/converter_cfg_regs.v ====
// converter configuration register bank behind an ahb-lite slave
// assumes a single master, word transfers, hready tied to hreadyout
`timescale 1ns/1ns
`include "cfg_consts.vh"
// Functional notes
// (R1) a set channel-select bit puts that input into the conversion cycle
// (R2) a clear channel-select bit skips that input in the conversion cycle
// (R3) four 4-bit settle codes, loop d high to loop a low, reset 0010
// (R4) settle codes 0 to 10 map 0.8 to 28.8 ms; higher codes invalid
// (R5) a set update-mode bit makes that output synchronous
// (R6) a clear update-mode bit makes it asynchronous, the reset state
// (R7) in closed loop the four primary outputs always update asynchronously
// (R8) a clear aux span bit gives the 0 to 5 V range
// (R9) a set aux span bit gives the 2.5 to 7.5 V range
// (R10) pair span 00 gives -4..1 V, 01/10 give -5..0 V, 11 gives 0..5 V
// (R11) software keeps reserved bits at zero
// (R12) channel select sits at index 0x12 and resets to zero
// (R13) all fields read back what was written, reset to printed values
module converter_cfg_regs (
    input wire hclk, // bus clock, 20 MHz
    input wire hresetn, // async reset, active low
    input wire hsel, // slave select
    input wire [31:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write when high
    input wire [2:0] hsize, // transfer size
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready
    output reg [31:0] hrdata, // read data
    output wire hreadyout, // slave ready, always high
    output wire hresp, // response, always okay
    input wire closed_loop_active, // closed-loop controllers running
    output wire [14:0] channel_include, // inputs taken into adc cycle
    output wire [3:0] settle_valid, // per-loop settle code is legal
    output wire [127:0] settle_cycles, // per-loop settle time in cycles
    output wire [7:0] output_sync, // 1 synchronous, 0 asynchronous
    output wire [3:0] aux_span_high, // 1 gives 2.5..7.5 V, 0 gives 0..5 V
    output wire [1:0] pair_span_neg4, // pair in -4..1 V
    output wire [1:0] pair_span_neg5, // pair in -5..0 V
    output wire [1:0] pair_span_pos5 // pair in 0..5 V
);
    // ************
    // bus slave
    // ************
    reg wr_pending;
    reg [7:0] wr_index;
    wire access;
    wire [7:0] addr_index;
    wire [15:0] channel_select_word;
    wire [15:0] loop_settling_word;
    wire [15:0] update_mode_word;
    wire [15:0] output_span_word;
    reg [15:0] next_rdata;

    assign access = hsel & hready & htrans[1];
    assign addr_index = haddr[9:2];
    // zero wait states; every access finishes with okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_index <= 8'h00;
        end else begin
            wr_pending <= access & hwrite;
            wr_index <= addr_index;
        end
    end

    always @* begin
        case (addr_index)
            `IDX_CHANNEL_SELECT: next_rdata = channel_select_word;
            `IDX_LOOP_SETTLING: next_rdata = loop_settling_word;
            `IDX_UPDATE_MODE: next_rdata = update_mode_word;
            `IDX_OUTPUT_SPAN: next_rdata = output_span_word;
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data is captured at the address phase; unmapped reads give zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (access & ~hwrite) begin
            hrdata <= {16'h0000, next_rdata}; // see (R13)
        end
    end

    // ************
    // register words
    // ************
    // reserved bits are masked off so a stray write cannot set them
    cfg_word #(
        .RESET_VALUE(`RST_CHANNEL_SELECT),
        .WRITE_MASK(`MASK_CHANNEL_SELECT)
    ) u_channel_select (
        .hclk(hclk),
        .hresetn(hresetn),
        .write_en(wr_pending & (wr_index == `IDX_CHANNEL_SELECT)), // see (R12)
        .write_data(hwdata[15:0]),
        .value(channel_select_word)
    );
    cfg_word #(
        .RESET_VALUE(`RST_LOOP_SETTLING),
        .WRITE_MASK(`MASK_LOOP_SETTLING)
    ) u_loop_settling (
        .hclk(hclk),
        .hresetn(hresetn),
        .write_en(wr_pending & (wr_index == `IDX_LOOP_SETTLING)), // see (R3)
        .write_data(hwdata[15:0]),
        .value(loop_settling_word)
    );
    cfg_word #(
        .RESET_VALUE(`RST_UPDATE_MODE),
        .WRITE_MASK(`MASK_UPDATE_MODE)
    ) u_update_mode (
        .hclk(hclk),
        .hresetn(hresetn),
        .write_en(wr_pending & (wr_index == `IDX_UPDATE_MODE)), // see (R6)
        .write_data(hwdata[15:0]),
        .value(update_mode_word)
    );
    cfg_word #(
        .RESET_VALUE(`RST_OUTPUT_SPAN),
        .WRITE_MASK(`MASK_OUTPUT_SPAN)
    ) u_output_span (
        .hclk(hclk),
        .hresetn(hresetn),
        .write_en(wr_pending & (wr_index == `IDX_OUTPUT_SPAN)), // see (R13)
        .write_data(hwdata[15:0]),
        .value(output_span_word)
    );

    // ************
    // field decode
    // ************
    wire local_temp_select;
    wire [1:0] remote_temp_select;
    wire [3:0] current_sense_select;
    wire [3:0] external_input_select;
    wire [3:0] internal_input_select;
    assign local_temp_select = channel_select_word[`POS_LOCAL_TEMP];
    assign remote_temp_select = channel_select_word[`POS_REMOTE_TEMP+:2];
    assign current_sense_select = channel_select_word[`POS_CURRENT_SENSE+:4];
    assign external_input_select = channel_select_word[`POS_EXTERNAL_IN+:4];
    assign internal_input_select = channel_select_word[`POS_INTERNAL_IN+:4];
    // a clear bit drops the input from the sequence
    assign channel_include = {local_temp_select, remote_temp_select,
        current_sense_select, external_input_select,
        internal_input_select}; // see (R1) see (R2)

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_loop
            settle_decode u_settle (
                .code(loop_settling_word[4*g+:4]), // see (R3)
                .tenths_ms(),
                .valid(settle_valid[g]), // see (R4)
                .cycles(settle_cycles[32*g+:32])
            );
        end
    endgenerate

    wire [3:0] aux_out_update_mode;
    wire [3:0] primary_out_update_mode;
    assign aux_out_update_mode = update_mode_word[`POS_AUX_FIELD+:4];
    assign primary_out_update_mode = update_mode_word[`POS_PRIMARY_FIELD+:4];
    // closed loop overrides the primary outputs only, bits stay stored
    assign output_sync = {aux_out_update_mode,
        primary_out_update_mode & {4{~closed_loop_active}}}; // see (R5) see (R7)

    wire [1:0] bipolar_pair_b_span;
    wire [1:0] bipolar_pair_a_span;
    assign aux_span_high = output_span_word[`POS_AUX_FIELD+:4]; // see (R8) see (R9)
    assign bipolar_pair_b_span = output_span_word[`POS_PAIR_B_SPAN+:2];
    assign bipolar_pair_a_span = output_span_word[`POS_PAIR_A_SPAN+:2];
    assign pair_span_neg4 = {bipolar_pair_b_span == `SPAN_NEG4_POS1,
        bipolar_pair_a_span == `SPAN_NEG4_POS1}; // see (R10)
    assign pair_span_neg5 = {
        (bipolar_pair_b_span == `SPAN_NEG5_ZERO_A) |
        (bipolar_pair_b_span == `SPAN_NEG5_ZERO_B),
        (bipolar_pair_a_span == `SPAN_NEG5_ZERO_A) |
        (bipolar_pair_a_span == `SPAN_NEG5_ZERO_B)}; // see (R10)
    assign pair_span_pos5 = {bipolar_pair_b_span == `SPAN_ZERO_POS5,
        bipolar_pair_a_span == `SPAN_ZERO_POS5}; // see (R10)
endmodule // converter_cfg_regs

// ==== tb/cfg_chk_monitor.sv ====
// checker for the converter configuration bank, bus side and outputs
// assumes it is bound to the bank top and sees only its ports
`timescale 1ns/1ns
module cfg_chk (
    input wire hclk, // clock
    input wire hresetn, // reset, active low
    input wire hsel, // select
    input wire [31:0] haddr, // address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready
    input wire [31:0] hrdata, // read data
    input wire hreadyout, // slave ready
    input wire hresp, // response
    input wire closed_loop_active, // closed loop
    input wire [14:0] channel_include, // adc inputs
    input wire [3:0] settle_valid, // legal codes
    input wire [127:0] settle_cycles, // settle times
    input wire [7:0] output_sync, // update modes
    input wire [3:0] aux_span_high, // aux spans
    input wire [1:0] pair_span_neg4, // pair -4..1
    input wire [1:0] pair_span_neg5, // pair -5..0
    input wire [1:0] pair_span_pos5 // pair 0..5
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // settle times in 0.1 ms, 2000 cycles each at 20 MHz
    localparam int tenth[11] = '{8,16,24,32,48,64,96,128,192,256,288};
    function automatic int unsigned cyc(input logic [3:0] c);
        return (c > 4'ha) ? 0 : tenth[c] * 2000;
    endfunction
    sequence wr(idx);
        hsel && hready && htrans[1] && hwrite && haddr[9:2] == idx;
    endsequence
    sequence rd_any;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    a_chan_write: assert property (
        wr(8'h12) |=> ##1 channel_include == $past(hwdata[14:0]))
        else $error("channel include wrong");
    a_settle_time: assert property (
        wr(8'h14) |=> ##1 settle_cycles[31:0] == cyc($past(hwdata[3:0]))
        && settle_valid[0] == ($past(hwdata[3:0]) <= 4'ha))
        else $error("settle decode wrong");
    a_sync_write: assert property (
        wr(8'h15) |=> ##1 output_sync == ($past(hwdata[7:0]) &
        {4'hf, {4{!closed_loop_active}}}))
        else $error("update mode wrong");
    a_closed_async: assert property (
        closed_loop_active |-> output_sync[3:0] == 4'h0)
        else $error("primary sync in closed loop");
    a_span_write: assert property (
        wr(8'h16) |=> ##1 aux_span_high == $past(hwdata[7:4]) &&
        pair_span_pos5[0] == ($past(hwdata[1:0]) == 2'h3))
        else $error("span decode wrong");
    a_span_onehot: assert property (
        $onehot({pair_span_neg4[1], pair_span_neg5[1], pair_span_pos5[1]})
        && $onehot({pair_span_neg4[0], pair_span_neg5[0], pair_span_pos5[0]}))
        else $error("pair span not one-hot");
    a_read_upper: assert property (
        rd_any |=> hrdata[31:16] == 16'h0000 && hreadyout && !hresp)
        else $error("read upper half or response wrong");
    a_reset_vals: assert property (
        $rose(hresetn) |-> channel_include == 15'h0000 && output_sync ==
        8'h00 && settle_cycles[31:0] == 48000 && pair_span_neg4 == 2'h3)
        else $error("reset outputs wrong");
endmodule // cfg_chk

// ==== tb/adc_dac_config_regs_tb.sv ====
// bench for the converter configuration bank, driven over ahb-lite
// assumes one word slave whose hreadyout is fed back as hready
`timescale 1ns/1ns
module adc_dac_config_regs_tb;
    logic hclk = 0, hresetn = 0, hwrite = 0, closed_loop_active = 0;
    logic hsel = 1;
    logic [31:0] haddr = 0, hwdata = 0, rv;
    logic [1:0] htrans = 0;
    wire [31:0] hrdata;
    wire hready, hresp;
    wire [14:0] channel_include;
    wire [3:0] settle_valid, aux_span_high;
    wire [127:0] settle_cycles;
    wire [7:0] output_sync;
    wire [1:0] neg4, neg5, pos5;
    int mismatches = 0, checks_done = 0;
    localparam int tenth[11] = '{8,16,24,32,48,64,96,128,192,256,288};
    always #25 hclk = ~hclk;
    converter_cfg_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp),
        .closed_loop_active(closed_loop_active),
        .channel_include(channel_include), .settle_valid(settle_valid),
        .settle_cycles(settle_cycles), .output_sync(output_sync),
        .aux_span_high(aux_span_high), .pair_span_neg4(neg4),
        .pair_span_neg5(neg5), .pair_span_pos5(pos5));
    // ********
    // bus and compare helpers
    // ********
    task chk(input string n, input [31:0] e, input [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // returns one step after the data phase so written outputs have landed
    task xfer(input w, input [31:0] a, input [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rv = hrdata;
        #1;
    endtask
    task rd_chk(input string n, input [31:0] a, input [31:0] e);
        xfer(0, a, 0);
        chk(n, e, rv);
        chk("resp", 0, 32'(hresp));
    endtask
    // ********
    // scenarios
    // ********
    // every output at its reset value, used after each reset release
    task reset_chk;
        rd_chk("channel", 'h48, 0);
        rd_chk("settle", 'h50, 'h2222);
        rd_chk("update", 'h54, 0);
        rd_chk("span", 'h58, 0);
        for (int i = 0; i < 4; i++)
            chk("cycles", 48000, settle_cycles[i*32+:32]);
        chk("valid", 'hf, 32'(settle_valid));
        chk("include", 0, 32'(channel_include));
        chk("sync", 0, 32'(output_sync));
        chk("aux", 0, 32'(aux_span_high));
        chk("neg4", 3, 32'(neg4));
        chk("neg5", 0, 32'(neg5));
        chk("pos5", 0, 32'(pos5));
    endtask
    task test_reset;
        reset_chk;
        $display("test_reset done");
    endtask
    // reserved bits are always written as zero, as software must
    task test_channel;
        xfer(1, 'h48, 'h7fff);
        chk("include", 'h7fff, 32'(channel_include));
        rd_chk("channel", 'h48, 'h7fff);
        xfer(1, 'h48, 'h4001);
        chk("include", 'h4001, 32'(channel_include));
        hsel <= 0;
        xfer(1, 'h48, 'h0ff0);
        hsel <= 1;
        chk("include", 'h4001, 32'(channel_include));
        xfer(1, 'h4c, 'hffff);
        rd_chk("unmapped", 'h4c, 0);
        rd_chk("channel", 'h48, 'h4001);
        $display("test_channel done");
    endtask
    // codes above the top one are never written, as software must
    task test_settle;
        for (int c = 0; c < 11; c++) begin
            xfer(1, 'h50, {4{c[3:0]}});
            chk("cycles", tenth[c] * 2000, settle_cycles[31:0]);
            chk("loop d", tenth[c] * 2000, settle_cycles[127:96]);
            chk("valid", 'hf, 32'(settle_valid));
            rd_chk("settle", 'h50, {4{c[3:0]}});
        end
        xfer(1, 'h50, 'h0a35);
        chk("loop d", 16000, settle_cycles[127:96]);
        chk("loop c", 576000, settle_cycles[95:64]);
        $display("test_settle done");
    endtask
    task test_update;
        xfer(1, 'h54, 'h00ff);
        chk("sync", 'hff, 32'(output_sync));
        rd_chk("update", 'h54, 'hff);
        @(posedge hclk);
        closed_loop_active <= 1;
        #1;
        chk("sync", 'hf0, 32'(output_sync));
        xfer(1, 'h54, 'h00a5);
        chk("sync", 'ha0, 32'(output_sync));
        @(posedge hclk);
        closed_loop_active <= 0;
        #1;
        chk("sync", 'ha5, 32'(output_sync));
        $display("test_update done");
    endtask
    task test_span;
        logic [1:0] pa, pb;
        logic [3:0] aux;
        for (int k = 0; k < 4; k++) begin
            pa = k;
            pb = 3 - k;
            aux = 4'h1 << k;
            xfer(1, 'h58, {8'h00, aux, pb, pa});
            chk("aux", aux, 32'(aux_span_high));
            chk("neg4", 32'({pb == 0, pa == 0}), 32'(neg4));
            chk("neg5", 32'({pb == 1 || pb == 2, pa == 1 || pa == 2}),
                32'(neg5));
            chk("pos5", 32'({pb == 3, pa == 3}), 32'(pos5));
            rd_chk("span", 'h58, {aux, pb, pa});
        end
        $display("test_span done");
    endtask
    // a reset in mid-run must bring every word back to its reset value
    task test_rereset;
        xfer(1, 'h48, 'h1234);
        xfer(1, 'h50, 'h5a39);
        xfer(1, 'h54, 'h0081);
        xfer(1, 'h58, 'h00c7);
        chk("include", 'h1234, 32'(channel_include));
        @(posedge hclk);
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        reset_chk;
        $display("test_rereset done");
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        test_reset;
        test_channel;
        test_settle;
        test_update;
        test_span;
        test_rereset;
        end_sim;
    end
    // the tests need about 8500 ns; this is a generous bound
    initial begin
        #500000;
        mismatches++;
        end_sim;
    end
endmodule // adc_dac_config_regs_tb
bind converter_cfg_regs cfg_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .closed_loop_active(closed_loop_active),
    .channel_include(channel_include), .settle_valid(settle_valid),
    .settle_cycles(settle_cycles), .output_sync(output_sync),
    .aux_span_high(aux_span_high), .pair_span_neg4(pair_span_neg4),
    .pair_span_neg5(pair_span_neg5), .pair_span_pos5(pair_span_pos5));
